// File: hdl/gdfs_core.sv
// fault supervision, pwm gating and serial frame checking of the gate driver
//
// Behaviour
// - short circuit latches flag, kills pwm, unmaskable
// - short circuit threshold and filter are configurable
// - enforce dead time; violation sets maskable flag
// - overcurrent latches unmaskable flag, pwm stays on
// - overcurrent threshold and filter are configurable
// - die started alone at init sets watchdog flag
// - open bus at init may flag serial error
// - clock count not multiple of 24 flags error
// - bad crc in message flags serial error
// - chip-select gap under 19 us flags error
// - self-test may also clear serial error
// - logic undervoltage freezes the transmit buffer
// - response returns the address it answers
// - hv overvoltage kills pwm and sets flag
// - reference undervoltage flag sticky, reasserts while present
// - hv regulator undervoltage flag sticky until cleared
// - alternate select enforces or bypasses dead time
// - unpowered hv domain freezes its data
// - failsafe input low disables pwm
// - config mode bit disables pwm until cleared
// - gate monitor fault locks pwm, maskable, delayed
`timescale 1ns/100ps
module gdfs_core #(
  parameter int FLT_W = 7,
  parameter int DT_W = 11
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial port, chip-select framed
  input wire logic chip_select_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  // pwm commands and gated outputs
  input wire logic pwm_high_in,
  input wire logic pwm_low_in,
  input wire logic alternate_pwm_select,
  input wire logic failsafe_enable_n,
  output logic pwm_high_out,
  output logic pwm_low_out,
  // raw detector levels
  input wire logic short_circuit_det,
  input wire logic overcurrent_det,
  input wire logic hv_overvoltage_det,
  input wire logic hv_regulator_uv_det,
  input wire logic reference_uv_det,
  input wire logic gate_voltage_det,
  // supplies and dies
  input wire logic hv_domain_powered,
  input wire logic hv_die_active,
  input wire logic logic_supply_undervoltage,
  input wire logic bist_clear,
  // status and analog thresholds
  output logic [gdfs_pkg::ST1_W-1:0] first_status_reg,
  output logic [gdfs_pkg::ST2_W-1:0] second_status_reg,
  output logic [3:0] short_circuit_threshold,
  output logic [3:0] overcurrent_threshold
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  gdfs_pkg::gdfs_phase_e phase; // startup phase
  logic [gdfs_pkg::DATA_W-1:0] second_mask_reg; // maskable flag enables
  logic [gdfs_pkg::DATA_W-1:0] overcurrent_config_reg;
  logic [gdfs_pkg::DATA_W-1:0] short_circuit_config_reg;
  logic [gdfs_pkg::DATA_W-1:0] dead_time_config_reg;
  logic [gdfs_pkg::DATA_W-1:0] mode_reg; // holds config-mode bit
  logic [gdfs_pkg::DATA_W-1:0] gate_monitor_reg; // monitor delay
  logic sclk_d; // previous serial clock
  logic cs_d; // previous chip select
  logic [4:0] bit_cnt; // bit position inside a 24 bit frame
  logic [gdfs_pkg::FRAME_BITS-2:0] rx_shift; // received bits
  logic [gdfs_pkg::FRAME_BITS-1:0] tx_shift; // bits going out
  logic [gdfs_pkg::FRAME_BITS-1:0] tx_buffer; // next response
  logic [gdfs_pkg::GAP_W-1:0] gap_cnt; // cycles chip select high
  logic frame_seen; // a frame has ended since reset
  logic [DT_W-1:0] idle_cnt; // cycles with both outputs off
  logic sc_hit, oc_hit, gate_hit; // filtered detects
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic frame_done; // 24th bit sampled this cycle
  logic [gdfs_pkg::FRAME_BITS-1:0] rx_word;
  logic crc_ok, wr_ok, cfg_mode;
  logic [gdfs_pkg::ADDR_W-1:0] rx_addr;
  logic [gdfs_pkg::DATA_W-1:0] rx_data, rd_data;
  logic [15:0] tx_head;
  logic len_err, gap_err, init_serr;
  logic [gdfs_pkg::ST1_W-1:0] st1_set, st1_clr;
  logic [gdfs_pkg::ST2_W-1:0] st2_set, st2_clr;
  logic pwm_en, dt_viol, next_high, next_low, dt_ok;

  // ----------------------------------------
  // filters for hv detectors
  // ----------------------------------------
  gdfs_filter #(.W(FLT_W)) u_sc_filt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .level(short_circuit_det),
    .delay(short_circuit_config_reg[gdfs_pkg::FLT_HI:gdfs_pkg::FLT_LO]),
    .hit(sc_hit)
  );
  gdfs_filter #(.W(FLT_W)) u_oc_filt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .level(overcurrent_det),
    .delay(overcurrent_config_reg[gdfs_pkg::FLT_HI:gdfs_pkg::FLT_LO]),
    .hit(oc_hit)
  );
  gdfs_filter #(.W(gdfs_pkg::DATA_W)) u_gate_filt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .level(gate_voltage_det),
    .delay(gate_monitor_reg),
    .hit(gate_hit)
  );

  // ----------------------------------------
  // serial edge and frame decode
  // ----------------------------------------
  assign sclk_rise = spi_sclk & ~sclk_d;
  assign sclk_fall = ~spi_sclk & sclk_d;
  assign cs_fall = cs_d & ~chip_select_n;
  assign cs_rise = ~cs_d & chip_select_n;
  assign frame_done = sclk_rise & ~chip_select_n & (bit_cnt == gdfs_pkg::LAST_BIT);
  assign rx_word = {rx_shift, spi_mosi};
  assign rx_addr = rx_word[gdfs_pkg::ADDR_HI:gdfs_pkg::ADDR_LO];
  assign rx_data = rx_word[gdfs_pkg::DATA_HI:gdfs_pkg::DATA_LO];
  assign crc_ok = gdfs_pkg::gdfs_crc8(rx_word[gdfs_pkg::ADDR_HI:gdfs_pkg::DATA_LO])
                  == rx_word[gdfs_pkg::CRC_HI:0];
  assign wr_ok = frame_done & crc_ok & rx_word[gdfs_pkg::WR_BIT];
  assign cfg_mode = mode_reg[gdfs_pkg::MODE_CFG];
  assign len_err = cs_rise & (bit_cnt != 5'h00);
  assign gap_err = cs_fall & frame_seen & (gap_cnt < gdfs_pkg::GAP_W'(gdfs_pkg::GAP_CYC));
  assign init_serr = (phase == gdfs_pkg::PH_INIT) & ~chip_select_n;

  // edge history
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_d <= spi_sclk;
      cs_d <= chip_select_n;
    end
  end

  // receive shifter and bit counter, restart on each select
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bit_cnt <= 5'h00;
      rx_shift <= '0;
    end else if (cs_fall) begin
      bit_cnt <= 5'h00;
    end else if (sclk_rise & ~chip_select_n) begin
      rx_shift <= rx_word[gdfs_pkg::FRAME_BITS-2:0];
      bit_cnt <= frame_done ? 5'h00 : bit_cnt + 5'h01;
    end
  end

  // inter-frame gap counter, saturating
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gap_cnt <= '0;
      frame_seen <= 1'b0;
    end else begin
      if (!chip_select_n) begin
        gap_cnt <= '0;
      end else if (gap_cnt < gdfs_pkg::GAP_W'(gdfs_pkg::GAP_CYC)) begin
        gap_cnt <= gap_cnt + 1'b1;
      end
      if (cs_rise) begin
        frame_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // response path
  // ----------------------------------------
  // read mux for the response data field
  always_comb begin
    case (rx_addr)
      gdfs_pkg::ADDR_STAT1: rd_data = gdfs_pkg::DATA_W'(first_status_reg);
      gdfs_pkg::ADDR_STAT2: rd_data = gdfs_pkg::DATA_W'(second_status_reg);
      gdfs_pkg::ADDR_MASK2: rd_data = second_mask_reg;
      gdfs_pkg::ADDR_OC_CFG: rd_data = overcurrent_config_reg;
      gdfs_pkg::ADDR_SC_CFG: rd_data = short_circuit_config_reg;
      gdfs_pkg::ADDR_DT_CFG: rd_data = dead_time_config_reg;
      gdfs_pkg::ADDR_MODE: rd_data = mode_reg;
      gdfs_pkg::ADDR_GMON: rd_data = gate_monitor_reg;
      default: rd_data = '0;
    endcase
  end
  assign tx_head = {rx_addr, 1'b0, rd_data};

  // response buffer, frozen under logic supply undervoltage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_buffer <= '0;
    end else if (frame_done & crc_ok & ~logic_supply_undervoltage) begin
      tx_buffer <= {tx_head, gdfs_pkg::gdfs_crc8(tx_head)};
    end
  end

  // transmit shifter, loaded at select only, shifted out on falling sclk
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_shift <= '0;
      spi_miso <= 1'b0;
    end else begin
      if (cs_fall) begin
        tx_shift <= tx_buffer;
      end else if (sclk_fall & ~chip_select_n) begin
        tx_shift <= {tx_shift[gdfs_pkg::FRAME_BITS-2:0], 1'b0};
      end
      spi_miso <= tx_shift[gdfs_pkg::FRAME_BITS-1];
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // mode always writable; others only in config mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_reg <= gdfs_pkg::MODE_RST;
      second_mask_reg <= gdfs_pkg::MASK2_RST;
      overcurrent_config_reg <= gdfs_pkg::OC_CFG_RST;
      short_circuit_config_reg <= gdfs_pkg::SC_CFG_RST;
      dead_time_config_reg <= gdfs_pkg::DT_CFG_RST;
      gate_monitor_reg <= gdfs_pkg::GMON_RST;
    end else if (wr_ok) begin
      if (rx_addr == gdfs_pkg::ADDR_MODE) begin
        mode_reg <= rx_data;
      end else if (cfg_mode) begin
        case (rx_addr)
          gdfs_pkg::ADDR_MASK2: second_mask_reg <= rx_data;
          gdfs_pkg::ADDR_OC_CFG: overcurrent_config_reg <= rx_data;
          gdfs_pkg::ADDR_SC_CFG: short_circuit_config_reg <= rx_data;
          gdfs_pkg::ADDR_DT_CFG: dead_time_config_reg <= rx_data;
          gdfs_pkg::ADDR_GMON: gate_monitor_reg <= rx_data;
          default: ;
        endcase
      end
    end
  end

  // threshold fields out to the comparators
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      short_circuit_threshold <= 4'h0;
      overcurrent_threshold <= 4'h0;
    end else begin
      short_circuit_threshold <= short_circuit_config_reg[gdfs_pkg::THR_HI:gdfs_pkg::THR_LO];
      overcurrent_threshold <= overcurrent_config_reg[gdfs_pkg::THR_HI:gdfs_pkg::THR_LO];
    end
  end

  // ----------------------------------------
  // startup phase
  // ----------------------------------------
  // run once the hv die is up and select is high
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase <= gdfs_pkg::PH_INIT;
    end else begin
      case (phase)
        gdfs_pkg::PH_INIT: begin
          if (hv_die_active & chip_select_n) begin
            phase <= gdfs_pkg::PH_RUN;
          end
        end
        gdfs_pkg::PH_RUN: phase <= gdfs_pkg::PH_RUN;
        default: phase <= gdfs_pkg::PH_INIT;
      endcase
    end
  end

  // ----------------------------------------
  // status flags, set wins over clear
  // ----------------------------------------
  always_comb begin
    st1_set = '0;
    st2_set = '0;
    st1_set[gdfs_pkg::ST1_SC] = hv_domain_powered & sc_hit;
    st1_set[gdfs_pkg::ST1_OC] = hv_domain_powered & oc_hit;
    st1_set[gdfs_pkg::ST1_HVOV] = hv_domain_powered & hv_overvoltage_det;
    st1_set[gdfs_pkg::ST1_HVREGUV] = hv_domain_powered & hv_regulator_uv_det;
    st2_set[gdfs_pkg::ST2_DT] = dt_viol & second_mask_reg[gdfs_pkg::ST2_DT];
    st2_set[gdfs_pkg::ST2_WDOG] = (phase == gdfs_pkg::PH_INIT) & ~hv_die_active;
    st2_set[gdfs_pkg::ST2_SERR] = len_err | gap_err | init_serr | (frame_done & ~crc_ok);
    st2_set[gdfs_pkg::ST2_REFUV] = hv_domain_powered & reference_uv_det;
    st2_set[gdfs_pkg::ST2_GATE] = hv_domain_powered & gate_hit & second_mask_reg[gdfs_pkg::ST2_GATE];
    st1_clr = (wr_ok && rx_addr == gdfs_pkg::ADDR_STAT1) ? rx_data[gdfs_pkg::ST1_W-1:0] : '0;
    st2_clr = (wr_ok && rx_addr == gdfs_pkg::ADDR_STAT2) ? rx_data[gdfs_pkg::ST2_W-1:0] : '0;
    st2_clr[gdfs_pkg::ST2_SERR] = st2_clr[gdfs_pkg::ST2_SERR] | bist_clear;
  end

  // sticky flags held until a write-one clear; serial error also cleared by bist_clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      first_status_reg <= '0;
      second_status_reg <= '0;
    end else begin
      first_status_reg <= (first_status_reg & ~st1_clr) | st1_set;
      second_status_reg <= (second_status_reg & ~st2_clr) | st2_set;
    end
  end

  // ----------------------------------------
  // pwm path with dead time
  // ----------------------------------------
  assign pwm_en = ~first_status_reg[gdfs_pkg::ST1_SC]
                  & ~hv_overvoltage_det & ~first_status_reg[gdfs_pkg::ST1_HVOV]
                  & failsafe_enable_n
                  & ~cfg_mode
                  & ~second_status_reg[gdfs_pkg::ST2_GATE];
  assign dt_ok = idle_cnt >= DT_W'(dead_time_config_reg);
  // both on, or one turning on before the dead time ran out
  assign dt_viol = ~alternate_pwm_select & ((pwm_high_in & pwm_low_in)
                   | (pwm_high_in & ~pwm_high_out & ~dt_ok)
                   | (pwm_low_in & ~pwm_low_out & ~dt_ok));

  // bypass passes commands straight; otherwise hold off overlap
  always_comb begin
    if (alternate_pwm_select) begin
      next_high = pwm_en & pwm_high_in;
      next_low = pwm_en & pwm_low_in;
    end else begin
      next_high = pwm_en & pwm_high_in & ~pwm_low_in & (pwm_high_out | dt_ok);
      next_low = pwm_en & pwm_low_in & ~pwm_high_in & (pwm_low_out | dt_ok);
    end
  end

  // gated outputs and dead time counter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwm_high_out <= 1'b0;
      pwm_low_out <= 1'b0;
      idle_cnt <= '1;
    end else begin
      pwm_high_out <= next_high;
      pwm_low_out <= next_low;
      if (pwm_high_out | pwm_low_out) begin
        idle_cnt <= '0;
      end else if (idle_cnt != {DT_W{1'b1}}) begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence cs_rise_s;
    cs_rise ##0 (bit_cnt != 5'h00);
  endsequence
  sequence gap_short_s;
    cs_fall ##0 (frame_seen && gap_cnt < gdfs_pkg::GAP_W'(gdfs_pkg::GAP_CYC));
  endsequence

  sc_kills_pwm_a: assert property (first_status_reg[gdfs_pkg::ST1_SC] |=> !pwm_high_out && !pwm_low_out)
    else $error("pwm active with short-circuit flag");
  oc_keeps_pwm_a: assert property ((pwm_en && pwm_high_in && !pwm_low_in && pwm_high_out
                                    && $rose(first_status_reg[gdfs_pkg::ST1_OC])) |=> pwm_high_out)
    else $error("overcurrent disabled pwm");
  dt_flag_a: assert property ((!alternate_pwm_select && pwm_high_in && pwm_low_in && second_mask_reg[gdfs_pkg::ST2_DT]) |=> second_status_reg[gdfs_pkg::ST2_DT])
    else $error("dead time violation not flagged");
  no_overlap_a: assert property ((!alternate_pwm_select && !$past(alternate_pwm_select)) |-> !(pwm_high_out && pwm_low_out))
    else $error("overlap with dead time enforced");
  cfg_mode_a: assert property (cfg_mode |=> !pwm_high_out && !pwm_low_out)
    else $error("pwm active in config mode");
  failsafe_off_a: assert property (!failsafe_enable_n |=> !pwm_high_out && !pwm_low_out)
    else $error("pwm active with failsafe low");
  frame_len_a: assert property (cs_rise_s |=> second_status_reg[gdfs_pkg::ST2_SERR])
    else $error("bad frame length not flagged");
  gap_check_a: assert property (gap_short_s |=> second_status_reg[gdfs_pkg::ST2_SERR])
    else $error("short gap not flagged");
  uv_freeze_a: assert property (logic_supply_undervoltage |=> $stable(tx_buffer))
    else $error("response changed under undervoltage");
  hv_ov_a: assert property (hv_overvoltage_det |=> !pwm_high_out && !pwm_low_out ##0 first_status_reg[gdfs_pkg::ST1_HVOV] || !hv_domain_powered)
    else $error("overvoltage did not disable pwm");
  flag_hold_a: assert property ((first_status_reg[gdfs_pkg::ST1_OC] && !wr_ok) |=> first_status_reg[gdfs_pkg::ST1_OC])
    else $error("overcurrent flag dropped without clear");

endmodule

// File: hdl/gdfs_pkg.sv
// constants, field layouts and types for the gate driver fault and serial check block
package gdfs_pkg;

  // ----------------------------------------
  // serial frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 11;
  localparam int CRC_W = 8;
  localparam int ADDR_HI = 23;
  localparam int ADDR_LO = 20;
  localparam int WR_BIT = 19;
  localparam int DATA_HI = 18;
  localparam int DATA_LO = 8;
  localparam int CRC_HI = 7;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam logic [CRC_W-1:0] CRC_INIT = 8'hFF;
  localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;

  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_STAT1 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT2 = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_MASK2 = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_OC_CFG = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_SC_CFG = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_DT_CFG = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_GMON = 4'h7;

  // ----------------------------------------
  // status and mask bit positions
  // ----------------------------------------
  localparam int ST1_W = 4;
  localparam int ST1_SC = 0;
  localparam int ST1_OC = 1;
  localparam int ST1_HVOV = 2;
  localparam int ST1_HVREGUV = 3;
  localparam int ST2_W = 5;
  localparam int ST2_DT = 0;
  localparam int ST2_WDOG = 1;
  localparam int ST2_SERR = 2;
  localparam int ST2_REFUV = 3;
  localparam int ST2_GATE = 4;
  localparam int MODE_CFG = 0;

  // ----------------------------------------
  // config fields and reset values
  // ----------------------------------------
  localparam int THR_HI = 3;
  localparam int THR_LO = 0;
  localparam int FLT_HI = 10;
  localparam int FLT_LO = 4;
  localparam logic [DATA_W-1:0] MASK2_RST = 11'h7FF;
  localparam logic [DATA_W-1:0] MODE_RST = 11'h001;
  localparam logic [DATA_W-1:0] OC_CFG_RST = 11'h048;
  localparam logic [DATA_W-1:0] SC_CFG_RST = 11'h028;
  localparam logic [DATA_W-1:0] DT_CFG_RST = 11'h014;
  localparam logic [DATA_W-1:0] GMON_RST = 11'h040;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 25;
  localparam int GAP_NS = 19000;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_W = $clog2(GAP_CYC + 1);

  // startup phase, one-hot
  typedef enum logic [1:0] {
    PH_INIT = 2'h1,
    PH_RUN = 2'h2
  } gdfs_phase_e;

  // crc over the 16 header and data bits, msb first
  function automatic logic [CRC_W-1:0] gdfs_crc8(input logic [15:0] d);
    logic [CRC_W-1:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

endpackage

// File: hdl/gdfs_filter.sv
// level filter: reports a detect once it has held for a programmed count
`timescale 1ns/100ps
module gdfs_filter #(
  parameter int W = 7
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // raw level and programmed count
  input wire logic level,
  input wire logic [W-1:0] delay,
  // filtered result
  output logic hit
);

  logic [W-1:0] cnt; // cycles the level has held

  // count while the level holds, restart when it drops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt <= '0;
      hit <= 1'b0;
    end else if (!level) begin
      cnt <= '0;
      hit <= 1'b0;
    end else begin
      if (cnt != {W{1'b1}}) begin
        cnt <= cnt + 1'b1;
      end
      hit <= (cnt >= delay);
    end
  end

endmodule

// File: dv/gdfs_host.sv
// host model: serial master framing 24-bit commands and capturing responses
`timescale 1ns/100ps
module gdfs_host (
  // clock
  input wire logic clk_sys,
  // serial lines
  output logic chip_select_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // select stays low until the host first drives the bus
  initial begin
    chip_select_n = 1'b0;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end

  // crc8 over header and data, msb first
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // idle gap, select, nbits msb first, release; bad flips the crc lsb
  task automatic send(input logic [3:0] a, input logic wr, input logic [10:0] d, input int nbits,
                      input logic bad, input int gap, output logic [23:0] rsp);
    logic [23:0] w;
    w = {a, wr, d, 8'h00};
    w[7:0] = crc8(w[23:8]) ^ {7'h00, bad};
    rsp = 24'h000000;
    @(posedge clk_sys);
    chip_select_n <= 1'b1;
    repeat (gap) @(posedge clk_sys);
    chip_select_n <= 1'b0;
    // sclk idles low and only runs inside the frame
    for (int i = 23; i > 23 - nbits; i--) begin
      repeat (2) @(posedge clk_sys);
      spi_mosi <= w[i];
      repeat (2) @(posedge clk_sys);
      rsp = {rsp[22:0], spi_miso};
      spi_sclk <= 1'b1;
      repeat (2) @(posedge clk_sys);
      spi_sclk <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
    chip_select_n <= 1'b1;
    // released data line has no pull: show the inverse of the last bit
    spi_mosi <= ~spi_mosi;
  endtask
endmodule

// File: dv/gdfs_core_bench.sv
// self-checking bench for the gate driver fault and serial check core
`timescale 1ns/100ps
module gdfs_core_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys, rst_n, cs_n, sclk, mosi, miso, hi_in, lo_in, alt_sel, fs_n, hi_out, lo_out;
  logic sc_det, oc_det, ov_det, reguv_det, hv_pwr, die_up, luv, bist, ref_det, gate_det;
  logic [gdfs_pkg::ST1_W-1:0] st1;
  logic [gdfs_pkg::ST2_W-1:0] st2;
  logic [3:0] sc_thr, oc_thr;
  logic [23:0] rsp;
  int failures, samples_checked;

  gdfs_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .chip_select_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
    .spi_miso(miso), .pwm_high_in(hi_in), .pwm_low_in(lo_in), .alternate_pwm_select(alt_sel),
    .failsafe_enable_n(fs_n), .pwm_high_out(hi_out), .pwm_low_out(lo_out), .short_circuit_det(sc_det),
    .overcurrent_det(oc_det), .hv_overvoltage_det(ov_det), .hv_regulator_uv_det(reguv_det),
    .reference_uv_det(ref_det), .gate_voltage_det(gate_det), .hv_domain_powered(hv_pwr), .hv_die_active(die_up),
    .logic_supply_undervoltage(luv), .bist_clear(bist), .first_status_reg(st1), .second_status_reg(st2),
    .short_circuit_threshold(sc_thr), .overcurrent_threshold(oc_thr));
  gdfs_host host (.clk_sys(clk_sys), .chip_select_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso));

  // 40 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    host.send(a, 1'b1, d, 24, 1'b0, 800, rsp);
    tick(2);
  endtask
  task automatic rd(input logic [3:0] a);
    host.send(a, 1'b0, 11'h000, 24, 1'b0, 800, rsp);
  endtask
  task automatic summarize();
    $display("checks made %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // startup faults, threshold setup, mode bit and failsafe gating
  task automatic t_init();
    tick(5);
    chk(st2[gdfs_pkg::ST2_WDOG], 1'b1);
    chk(st2[gdfs_pkg::ST2_SERR], 1'b1);
    chk({sc_thr, oc_thr}, 8'h88);
    die_up <= 1'b1;
    wr(gdfs_pkg::ADDR_STAT2, 11'h006);
    chk(st2, 5'h00);
    wr(gdfs_pkg::ADDR_SC_CFG, 11'h023);
    wr(gdfs_pkg::ADDR_OC_CFG, 11'h041);
    chk({sc_thr, oc_thr}, 8'h31);
    hi_in <= 1'b1;
    tick(30);
    chk(hi_out, 1'b0);
    wr(gdfs_pkg::ADDR_MODE, 11'h000);
    tick(4);
    chk(hi_out, 1'b1);
    fs_n <= 1'b0;
    tick(3);
    chk(hi_out, 1'b0);
    fs_n <= 1'b1;
    $display("test init done");
  endtask
  // kind 0 short circuit, 1 overcurrent, 2 hv overvoltage
  task automatic fault(input int kind);
    tick(30);
    {ov_det, oc_det, sc_det} <= 3'b001 << kind;
    tick(12);
    {ov_det, oc_det, sc_det} <= 3'b000;
    chk(st1, 4'h1 << kind);
    chk(hi_out, kind == 1);
    tick(5);
    chk(st1[kind], 1'b1);
    wr(gdfs_pkg::ADDR_STAT1, 11'h001 << kind);
    chk(st1, 4'h0);
    tick(30);
    chk(hi_out, 1'b1);
    $display("test fault %0d done", kind);
  endtask
  // overlapping commands: enforced, then bypassed
  task automatic t_dead();
    wr(gdfs_pkg::ADDR_STAT2, 11'h001);
    chk(st2[gdfs_pkg::ST2_DT], 1'b0);
    lo_in <= 1'b1;
    tick(4);
    chk(st2[gdfs_pkg::ST2_DT], 1'b1);
    chk({hi_out, lo_out}, 2'b00);
    alt_sel <= 1'b1;
    tick(4);
    chk({hi_out, lo_out}, 2'b11);
    {alt_sel, lo_in} <= 2'b00;
    wr(gdfs_pkg::ADDR_STAT2, 11'h001);
    chk(st2, 5'h00);
    $display("test dead time done");
  endtask
  // regulator flag frozen while hv unpowered, sticky once powered
  task automatic t_hv();
    {hv_pwr, reguv_det} <= 2'b01;
    tick(6);
    chk(st1[gdfs_pkg::ST1_HVREGUV], 1'b0);
    hv_pwr <= 1'b1;
    tick(6);
    reguv_det <= 1'b0;
    tick(6);
    chk(st1[gdfs_pkg::ST1_HVREGUV], 1'b1);
    wr(gdfs_pkg::ADDR_STAT1, 11'h008);
    chk(st1, 4'h0);
    $display("test hv supply done");
  endtask
  // reference flag sticky and reasserting; gate fault locks pwm until cleared
  task automatic t_ref_gate();
    ref_det <= 1'b1;
    tick(4);
    chk(st2[gdfs_pkg::ST2_REFUV], 1'b1);
    wr(gdfs_pkg::ADDR_STAT2, 11'h008);
    chk(st2[gdfs_pkg::ST2_REFUV], 1'b1);
    ref_det <= 1'b0;
    tick(4);
    chk(st2[gdfs_pkg::ST2_REFUV], 1'b1);
    wr(gdfs_pkg::ADDR_STAT2, 11'h008);
    chk(st2[gdfs_pkg::ST2_REFUV], 1'b0);
    gate_det <= 1'b1;
    tick(80);
    gate_det <= 1'b0;
    chk({st2[gdfs_pkg::ST2_GATE], hi_out}, 2'b10);
    wr(gdfs_pkg::ADDR_STAT2, 11'h010);
    tick(30);
    chk({st2[gdfs_pkg::ST2_GATE], hi_out}, 2'b01);
    $display("test reference and gate done");
  endtask
  // bad crc, 23-bit frame, short gap; last one cleared by self-test
  task automatic t_serial();
    for (int k = 0; k < 3; k++) begin
      host.send(gdfs_pkg::ADDR_STAT1, 1'b0, 11'h000, (k == 1) ? 23 : 24, k == 0, (k == 2) ? 100 : 800, rsp);
      tick(3);
      chk(st2[gdfs_pkg::ST2_SERR], 1'b1);
      if (k == 2) begin
        bist <= 1'b1;
        tick(1);
        bist <= 1'b0;
        tick(2);
      end else begin
        wr(gdfs_pkg::ADDR_STAT2, 11'h004);
      end
      chk(st2[gdfs_pkg::ST2_SERR], 1'b0);
    end
    $display("test serial error done");
  endtask
  // response echoes last address; frozen under logic undervoltage
  task automatic t_resp();
    rd(gdfs_pkg::ADDR_DT_CFG);
    rd(gdfs_pkg::ADDR_OC_CFG);
    chk(rsp[23:8], {gdfs_pkg::ADDR_DT_CFG, 1'b0, gdfs_pkg::DT_CFG_RST});
    luv <= 1'b1;
    rd(gdfs_pkg::ADDR_STAT1);
    rd(gdfs_pkg::ADDR_STAT2);
    chk(rsp[23:20], gdfs_pkg::ADDR_OC_CFG);
    luv <= 1'b0;
    $display("test response done");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    {rst_n, hi_in, lo_in, alt_sel, sc_det, oc_det, ov_det, reguv_det, luv, bist, die_up, ref_det, gate_det} = '0;
    {fs_n, hv_pwr} = 2'b11;
    failures = 0;
    samples_checked = 0;
    tick(8);
    rst_n <= 1'b1;
    t_init();
    for (int k = 0; k < 3; k++) begin
      fault(k);
    end
    t_dead();
    t_hv();
    t_ref_gate();
    t_serial();
    t_resp();
    summarize();
  end
  initial begin
    tick(60000);
    failures++;
    summarize();
  end
endmodule
